// file: core/mdu_pkg.sv
package mdu_pkg;

  // Register word indexes on the internal register port.
  localparam logic [2:0] ADDR_REMAINDER = 3'h0;
  localparam logic [2:0] ADDR_OPERAND_LOW = 3'h1;
  localparam logic [2:0] ADDR_OPERAND_HIGH = 3'h2;
  localparam logic [2:0] ADDR_OPERAND_B = 3'h3;
  localparam logic [2:0] ADDR_CONTROL = 3'h4;

  // Control register field positions.
  localparam int CTRL_START_BIT = 7;
  localparam int CTRL_MODE_BIT = 0;

  // Mode encoding of the mode select bit.
  localparam logic MODE_DIVIDE = 1'b0;
  localparam logic MODE_MULTIPLY = 1'b1;

  // Reset values.
  localparam logic [15:0] RESET_HALF = 16'h0000;
  localparam logic RESET_BIT = 1'b0;

  // Last step index of each operation (one short of its length in clocks), and the step counter width.
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] MUL_LAST_STEP = 5'h0F;
  localparam logic [CNT_W-1:0] DIV_LAST_STEP = 5'h1F;
  localparam logic [CNT_W-1:0] STEP_ONE = 5'h01;
  localparam logic [CNT_W-1:0] STEP_ZERO = 5'h00;

  // Merges a halfword write into an old value under the two byte enables.
  function automatic logic [15:0] merge_bytes(input logic [15:0] oldVal,
                                              input logic [15:0] newVal,
                                              input logic [1:0] byteEn);
    merge_bytes = oldVal;
    if (byteEn[0]) begin
      merge_bytes[7:0] = newVal[7:0];
    end
    if (byteEn[1]) begin
      merge_bytes[15:8] = newVal[15:8];
    end
  endfunction

endpackage

// file: core/mdu_step.sv
`timescale 1ns/100ps
// One iteration of shift-add multiply or restoring divide.
module mdu_step (
  input wire logic modeMul, // High selects the multiply step.
  input wire logic [31:0] opResult, // Current operand/result value.
  input wire logic [15:0] remainder, // Current partial remainder.
  input wire logic [15:0] operandB, // Multiplier B or divisor.
  output logic [31:0] opResultNext, // Operand/result after this step.
  output logic [15:0] remainderNext // Remainder after this step.
);

  // Multiply: add B to the high half when the low bit is set, then shift right.
  wire logic [16:0] mulSum;
  wire logic [32:0] mulShift;
  assign mulSum = opResult[0] ? ({1'b0, opResult[31:16]} + {1'b0, operandB})
                              : {1'b0, opResult[31:16]};
  assign mulShift = {mulSum, opResult[15:0]};

  // Divide: shift the next dividend bit into the remainder and try a subtraction.
  wire logic [16:0] divTrial;
  wire logic [16:0] divDiff;
  wire logic divFits;
  assign divTrial = {remainder, opResult[31]};
  assign divDiff = divTrial - {1'b0, operandB};
  assign divFits = (divTrial >= {1'b0, operandB});

  // Result selection between the two modes; the remainder stays put in multiply.
  assign opResultNext = modeMul ? mulShift[32:1] : {opResult[30:0], divFits};
  assign remainderNext = modeMul ? remainder
                                 : (divFits ? divDiff[15:0] : divTrial[15:0]);

endmodule

// file: core/mdu_core.sv
`timescale 1ns/100ps
// Sequential multiplier/divider with a halfword register port.
module mdu_core (
  input wire logic clock, // System clock, 25 MHz.
  input wire logic arst_n, // Asynchronous reset, active low.
  input wire logic [2:0] busAddr, // Register word index.
  input wire logic busWrEn, // Write strobe, one cycle.
  input wire logic busRdEn, // Read strobe, one cycle.
  input wire logic [1:0] busByteEn, // Byte enables for writes.
  input wire logic [15:0] busWrData, // Write data.
  output logic [15:0] busRdData, // Registered read data.
  output logic busRdValid, // Read data valid, one cycle.
  output logic arithDoneIrq // Completion interrupt pulse.
);

  // Architectural registers and sequencing state.
  logic [15:0] remainder_reg;
  logic [15:0] remainder_next;
  logic [31:0] opResult_reg;
  logic [31:0] opResult_next;
  logic [15:0] operandB_reg;
  logic [15:0] operandB_next;
  logic opStartBit_reg;
  logic opStartBit_next;
  logic opModeSelect_reg;
  logic opModeSelect_next;
  logic [mdu_pkg::CNT_W-1:0] stepCnt_reg;
  logic [mdu_pkg::CNT_W-1:0] stepCnt_next;
  logic donePending_reg;
  logic donePending_next;
  logic [15:0] rdData_reg;
  logic [15:0] rdData_next;
  logic rdValid_reg;
  logic irq_reg;

  // Address decode of the register port.
  // The remainder index decodes for reads only; writes to it change nothing.
  wire logic selRem;
  wire logic selLow;
  wire logic selHigh;
  wire logic selB;
  wire logic selCtrl;
  assign selRem = (busAddr == mdu_pkg::ADDR_REMAINDER);
  assign selLow = (busAddr == mdu_pkg::ADDR_OPERAND_LOW);
  assign selHigh = (busAddr == mdu_pkg::ADDR_OPERAND_HIGH);
  assign selB = (busAddr == mdu_pkg::ADDR_OPERAND_B);
  assign selCtrl = (busAddr == mdu_pkg::ADDR_CONTROL);

  // Control writes: new field values and start or stop events.
  wire logic ctrlWrite;
  wire logic wrStart;
  wire logic wrMode;
  wire logic startOp;
  wire logic stopOp;
  assign ctrlWrite = busWrEn && selCtrl && busByteEn[0];
  assign wrStart = busWrData[mdu_pkg::CTRL_START_BIT];
  assign wrMode = busWrData[mdu_pkg::CTRL_MODE_BIT];
  assign startOp = ctrlWrite && wrStart && !opStartBit_reg;
  assign stopOp = ctrlWrite && !wrStart && opStartBit_reg;

  // Mode decode shared by the step datapath and the completion count.
  wire logic isMulMode;
  assign isMulMode = (opModeSelect_reg == mdu_pkg::MODE_MULTIPLY);

  // Completion when the last step of the selected mode is taken.
  // The counter holds steps already taken, so the last index is one short of the length.
  wire logic [mdu_pkg::CNT_W-1:0] lastStep;
  wire logic finishOp;
  assign lastStep = isMulMode ? mdu_pkg::MUL_LAST_STEP
                              : mdu_pkg::DIV_LAST_STEP;
  assign finishOp = opStartBit_reg && (stepCnt_reg == lastStep);

  // Stepping runs while started; a stop on the final step edge loses to completion.
  wire logic stepEnable;
  assign stepEnable = opStartBit_reg && (!stopOp || finishOp);

  // One arithmetic step per clock while running.
  wire logic [31:0] stepOpResult;
  wire logic [15:0] stepRemainder;
  mdu_step mdu_step_inst (
    .modeMul(isMulMode),
    .opResult(opResult_reg),
    .remainder(remainder_reg),
    .operandB(operandB_reg),
    .opResultNext(stepOpResult),
    .remainderNext(stepRemainder)
  );

  // Software halfword writes merged into the current values.
  wire logic [15:0] lowWritten;
  wire logic [15:0] highWritten;
  wire logic [15:0] bWritten;
  assign lowWritten = mdu_pkg::merge_bytes(opResult_reg[15:0], busWrData, busByteEn);
  assign highWritten = mdu_pkg::merge_bytes(opResult_reg[31:16], busWrData, busByteEn);
  assign bWritten = mdu_pkg::merge_bytes(operandB_reg, busWrData, busByteEn);

  // Control register next state: start, self-clear at completion, software stop.
  // Completion clears start even when the same edge carries a software stop.
  always_comb begin
    opStartBit_next = opStartBit_reg;
    opModeSelect_next = opModeSelect_reg;
    if (ctrlWrite) begin
      opModeSelect_next = wrMode;
      opStartBit_next = wrStart;
    end
    if (finishOp) begin
      opStartBit_next = mdu_pkg::RESET_BIT;
    end
  end

  // Step counter restarts at each start and advances while running.
  // A stop or a completion returns it to zero so the next start counts afresh.
  always_comb begin
    stepCnt_next = stepCnt_reg;
    if (startOp || stopOp || finishOp) begin
      stepCnt_next = mdu_pkg::STEP_ZERO;
    end else if (opStartBit_reg) begin
      stepCnt_next = stepCnt_reg + mdu_pkg::STEP_ONE;
    end
  end

  // Remainder: cleared at start, stepped while running, never written by software.
  // Multiply steps pass the remainder through, so it stays zero to the end.
  always_comb begin
    remainder_next = remainder_reg;
    if (startOp) begin
      remainder_next = mdu_pkg::RESET_HALF;
    end else if (stepEnable) begin
      remainder_next = stepRemainder;
    end
  end

  // Operand/result: stepped from the clock after start; a software write wins on its whole halfword.
  // Byte writes during a run still land, which spoils the result of that run.
  always_comb begin
    opResult_next = opResult_reg;
    if (stepEnable) begin
      opResult_next = stepOpResult;
    end
    if (busWrEn && selLow) begin
      opResult_next[15:0] = lowWritten;
    end
    if (busWrEn && selHigh) begin
      opResult_next[31:16] = highWritten;
    end
    if (startOp && (wrMode == mdu_pkg::MODE_MULTIPLY)) begin
      opResult_next[31:16] = mdu_pkg::RESET_HALF;
    end
  end

  // Operand B is plain storage.
  assign operandB_next = (busWrEn && selB) ? bWritten : operandB_reg;

  // Done interrupt follows one clock after the start bit self-clears.
  // The extra cycle lets software see start low before the request arrives.
  assign donePending_next = finishOp;

  // Read multiplexer; unmapped indexes read zero.
  // The control word reads back only its start and mode bits.
  always_comb begin
    rdData_next = mdu_pkg::RESET_HALF;
    if (selRem) begin
      rdData_next = remainder_reg;
    end else if (selLow) begin
      rdData_next = opResult_reg[15:0];
    end else if (selHigh) begin
      rdData_next = opResult_reg[31:16];
    end else if (selB) begin
      rdData_next = operandB_reg;
    end else if (selCtrl) begin
      rdData_next[mdu_pkg::CTRL_START_BIT] = opStartBit_reg;
      rdData_next[mdu_pkg::CTRL_MODE_BIT] = opModeSelect_reg;
    end
  end

  // Arithmetic registers.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      remainder_reg <= mdu_pkg::RESET_HALF;
      opResult_reg <= {mdu_pkg::RESET_HALF, mdu_pkg::RESET_HALF};
      operandB_reg <= mdu_pkg::RESET_HALF;
    end else begin
      remainder_reg <= remainder_next;
      opResult_reg <= opResult_next;
      operandB_reg <= operandB_next;
    end
  end

  // Control and sequencing registers.
  // The step counter and the pending flag reset together with the control bits.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      opStartBit_reg <= mdu_pkg::RESET_BIT;
      opModeSelect_reg <= mdu_pkg::RESET_BIT;
      stepCnt_reg <= mdu_pkg::STEP_ZERO;
      donePending_reg <= mdu_pkg::RESET_BIT;
    end else begin
      opStartBit_reg <= opStartBit_next;
      opModeSelect_reg <= opModeSelect_next;
      stepCnt_reg <= stepCnt_next;
      donePending_reg <= donePending_next;
    end
  end

  // Output registers.
  // Read data holds between reads so a slow reader still sees it.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rdData_reg <= mdu_pkg::RESET_HALF;
      rdValid_reg <= mdu_pkg::RESET_BIT;
      irq_reg <= mdu_pkg::RESET_BIT;
    end else begin
      rdData_reg <= busRdEn ? rdData_next : rdData_reg;
      rdValid_reg <= busRdEn;
      irq_reg <= donePending_reg;
    end
  end

  // Ports come straight from their flip-flops.
  assign busRdData = rdData_reg;
  assign busRdValid = rdValid_reg;
  assign arithDoneIrq = irq_reg;

endmodule

// file: verif/mdu_core_monitor.sv
`timescale 1ns/100ps
// Watches the register port and the completion pulse of the unit.
module mdu_core_monitor (
  input wire logic clock, // System clock.
  input wire logic arst_n, // Reset, active low.
  input wire logic [2:0] busAddr, // Word index.
  input wire logic busWrEn, // Write strobe.
  input wire logic busRdEn, // Read strobe.
  input wire logic [1:0] busByteEn, // Byte enables.
  input wire logic [15:0] busWrData, // Write data.
  input wire logic [15:0] busRdData, // Read data.
  input wire logic busRdValid, // Read valid.
  input wire logic arithDoneIrq // Done pulse.
);
  logic [5:0] stepsLeft_reg;
  // Decodes control accesses.
  wire ctrlWr = busWrEn && busAddr == 3'h4 && busByteEn[0];
  wire ctrlRd = busRdEn && busAddr == 3'h4;
  // Counts the edges left until the done pulse; zero while idle.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      stepsLeft_reg <= 6'h00;
    end else if (ctrlWr && busWrData[7] && stepsLeft_reg == 6'h00) begin
      stepsLeft_reg <= busWrData[0] ? 6'h11 : 6'h21;
    end else if (ctrlWr && !busWrData[7] && stepsLeft_reg > 6'h02) begin
      stepsLeft_reg <= 6'h00;
    end else if (stepsLeft_reg != 6'h00) begin
      stepsLeft_reg <= stepsLeft_reg - 6'h01;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  a_read_answer: assert property (busRdEn |=> busRdValid)
    else $error("read strobe got no valid");
  a_valid_cause: assert property (busRdValid |-> $past(busRdEn))
    else $error("valid without a read");
  a_data_hold: assert property (!busRdEn |=> $stable(busRdData))
    else $error("read data moved without a read");
  a_void_index: assert property (busRdEn && busAddr > 3'h4 |=> busRdData == 16'h0000)
    else $error("unmapped index read nonzero");
  a_irq_timing: assert property (stepsLeft_reg == 6'h01 |=> arithDoneIrq)
    else $error("done pulse missing");
  a_irq_cause: assert property (arithDoneIrq |-> $past(stepsLeft_reg) == 6'h01)
    else $error("done pulse at wrong time");
  a_irq_single: assert property (arithDoneIrq |=> !arithDoneIrq)
    else $error("done pulse too long");
  a_start_busy: assert property (ctrlRd && stepsLeft_reg > 6'h01 |=> busRdData[7])
    else $error("start bit low while running");
  a_start_idle: assert property (ctrlRd && stepsLeft_reg < 6'h02 |=> !busRdData[7])
    else $error("start bit high while idle");
  a_ctrl_spare: assert property (ctrlRd |=> busRdData[15:8] == 8'h00 && busRdData[6:1] == 6'h00)
    else $error("spare control bits nonzero");
endmodule
bind mdu_core mdu_core_monitor mdu_core_monitor_inst (.clock, .arst_n, .busAddr, .busWrEn,
  .busRdEn, .busByteEn, .busWrData, .busRdData, .busRdValid, .arithDoneIrq);

// file: verif/mdu_core_test.sv
`timescale 1ns/100ps
// Drives the register port of the unit and checks the results.
module mdu_core_test;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic [2:0] busAddr = 3'h0;
  logic busWrEn = 1'b0;
  logic busRdEn = 1'b0;
  logic [1:0] busByteEn = 2'h0;
  logic [15:0] busWrData = 16'h0000;
  logic [15:0] busRdData;
  logic busRdValid;
  logic arithDoneIrq;
  int nErrors = 0;
  int compares = 0;
  int n;
  logic [31:0] expRes;
  logic [15:0] expRem;
  logic [31:0] opA [6] = '{32'hDCBA2586, 32'hFFFFFFFF, 32'h00000005, 32'h00001234,
    32'h0000FFFF, 32'h00000000};
  logic [15:0] opB [6] = '{16'h0018, 16'h0001, 16'h0007, 16'hFFFF, 16'hFFFF, 16'hABCD};
  // Clock at 25 MHz.
  always #20 clock = ~clock;
  mdu_core mdu_core_inst (.clock(clock), .arst_n(arst_n), .busAddr(busAddr),
    .busWrEn(busWrEn), .busRdEn(busRdEn), .busByteEn(busByteEn), .busWrData(busWrData),
    .busRdData(busRdData), .busRdValid(busRdValid), .arithDoneIrq(arithDoneIrq));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      nErrors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [1:0] be, input logic [15:0] d);
    @(posedge clock);
    busAddr <= a;
    busByteEn <= be;
    busWrData <= d;
    busWrEn <= 1'b1;
    @(posedge clock);
    busWrEn <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [15:0] exp);
    @(posedge clock);
    busAddr <= a;
    busRdEn <= 1'b1;
    @(posedge clock);
    busRdEn <= 1'b0;
    #1;
    chk(busRdData, exp);
    chk({15'h0000, busRdValid}, 16'h0001);
  endtask
  // Counts edges from the start edge to the done pulse.
  task automatic wait_done(input int expN);
    n = 0;
    while (arithDoneIrq !== 1'b1 && n < 100) begin
      @(posedge clock);
      #1;
      n++;
    end
    chk(n[15:0], expN[15:0]);
  endtask
  task automatic giveVerdict();
    if (nErrors == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Cuts a hang short well after the tests should have ended.
  initial begin
    #400000;
    nErrors++;
    giveVerdict();
  end
  // Main sequence of register accesses.
  initial begin
    repeat (16) @(posedge clock);
    arst_n <= 1'b1;
    for (int i = 0; i < 6; i++) rd(i[2:0], 16'h0000);
    wr(3'h1, 2'h1, 16'hEE34);
    wr(3'h1, 2'h2, 16'h12EE);
    rd(3'h1, 16'h1234);
    wr(3'h0, 2'h3, 16'hFFFF);
    rd(3'h0, 16'h0000);
    for (int i = 0; i < 6; i++) begin
      wr(3'h1, 2'h3, opA[i][15:0]);
      wr(3'h2, 2'h3, i > 2 ? 16'hBEEF : opA[i][31:16]);
      wr(3'h3, 2'h3, opB[i]);
      wr(3'h4, 2'h1, i > 2 ? 16'h0081 : 16'h0080);
      // Sixteen or thirty-two steps, then one more edge raises the done pulse.
      wait_done(i > 2 ? 17 : 33);
      expRes = i > 2 ? opA[i][15:0] * opB[i] : opA[i] / opB[i];
      expRem = i > 2 ? 16'h0000 : 16'(opA[i] % opB[i]);
      rd(3'h2, expRes[31:16]);
      rd(3'h1, expRes[15:0]);
      rd(3'h0, expRem);
      rd(3'h4, i > 2 ? 16'h0001 : 16'h0000);
    end
    wr(3'h4, 2'h1, 16'h0080);
    rd(3'h4, 16'h0080);
    wr(3'h4, 2'h1, 16'h0000);
    n = 0;
    repeat (40) begin
      @(posedge clock);
      n += (arithDoneIrq === 1'b1) ? 1 : 0;
    end
    chk(n[15:0], 16'h0000);
    rd(3'h4, 16'h0000);
    // A stop that lands on the final multiply step still completes with the product.
    wr(3'h1, 2'h3, 16'h00FF);
    wr(3'h3, 2'h3, 16'h0101);
    wr(3'h4, 2'h1, 16'h0081);
    repeat (14) @(posedge clock);
    wr(3'h4, 2'h1, 16'h0000);
    wait_done(1);
    rd(3'h1, 16'hFFFF);
    rd(3'h2, 16'h0000);
    wr(3'h4, 2'h1, 16'h0081);
    @(posedge clock);
    arst_n <= 1'b0;
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    rd(3'h4, 16'h0000);
    rd(3'h3, 16'h0000);
    giveVerdict();
  end
endmodule
